// ### hw/cmd_status_regs.vh
// register offsets, field positions, codes and timing of the command unit
`ifndef CMD_STATUS_REGS_VH
`define CMD_STATUS_REGS_VH

// ----------------------------------------------------------------------
// wishbone register map (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CMD        8'h00
`define OFS_REPLY      8'h04
`define OFS_STB        8'h08
`define OFS_ESE        8'h0C
`define OFS_ESR        8'h10
`define OFS_TST        8'h14

// ----------------------------------------------------------------------
// command opcodes, cmd register bits [3:0], argument in [15:8]
// ----------------------------------------------------------------------
`define OP_NOP         4'h0
`define OP_IDN_Q       4'h1
`define OP_RST         4'h2
`define OP_TST_Q       4'h3
`define OP_WAI         4'h4
`define OP_OPC         4'h5
`define OP_OPC_Q       4'h6
`define OP_CLS         4'h7
`define OP_ESE         4'h8
`define OP_ESE_Q       4'h9
`define OP_ESR_Q       4'hA

// ----------------------------------------------------------------------
// event status bits and status byte bits
// ----------------------------------------------------------------------
`define ESR_OPC        0
`define ESR_QERR       2
`define ESR_DERR       3
`define ESR_EERR       4
`define ESR_CERR       5
`define ESR_URQ        6
`define ESR_PON        7
`define STB_SWEEP_DONE 0
`define STB_MOD_EN     1
`define STB_MAV        4
`define STB_ESB        5
`define STB_ERR        7

// ----------------------------------------------------------------------
// self-test result codes
// ----------------------------------------------------------------------
`define TST_PASS       8'h00
`define TST_CPU        8'h01
`define TST_RAM        8'h02
`define TST_ROM        8'h03
`define TST_KEYPAD     8'h04
`define TST_CONV       8'h05

// ----------------------------------------------------------------------
// instrument defaults after a device reset
// ----------------------------------------------------------------------
`define WAVE_SINE      2'h0
`define DEF_FREQ_HZ    32'h0000_03E8
`define DEF_AMPL_MV    16'h03E8
`define DEF_OFFS_MV    16'h0000

// ----------------------------------------------------------------------
// ascii characters and timing
// ----------------------------------------------------------------------
`define CH_ZERO        8'h30
`define CH_ONE         8'h31
`define CH_COMMA       8'h2C
`define CH_LF          8'h0A
`define CLK_PERIOD_NS  100
`define TST_TIME_NS    1000000

`endif

// ### hw/cmd_status_unit.v
// common command interpreter with event status, enable mask and replies
// Overview of operation
// - self-test query runs the internal test, then replies a number
// - a clean self-test replies zero
// - every nonzero self-test reply means failure or error
// - processor fault reports code 1
// - working memory fault reports code 2
// - firmware checksum fault reports code 3
// - wait-to-continue blocks further commands until operations finish
// - operation-complete command sets event bit 0 once nothing pending
// - operation-complete query queues ascii 1 once nothing pending
// - clear-status zeroes the event status register and status byte bit 7
// - clear-status keeps the reply queue and message-available bit
// - event-enable command loads the mask from its decimal argument
// - set mask bits enable the matching event status bits
// - event-enable query replies the mask in decimal, all ones 255
// - event status query replies in decimal and clears the register
// - device reset keeps queue, enable masks, bus state and calibration
// - status byte bit 4 is set while the reply queue holds data
// - status byte bit 5 is set when an enabled event bit is set
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "cmd_status_regs.vh"

module cmd_status_unit #(
   parameter        SELFTEST_CYCLES = `TST_TIME_NS / `CLK_PERIOD_NS,
   parameter        QUEUE_DEPTH     = 16,
   parameter        QUEUE_AW        = 4,
   parameter [15:0] MAKER_TAG       = 16'h4142, // arbitrary value
   parameter [15:0] MODEL_TAG       = 16'h3031  // arbitrary value
) (
   input  wire        core_clk_i,
   input  wire        srst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        op_busy_i,
   input  wire        sweep_busy_i,
   input  wire        exec_err_i,
   input  wire        dev_err_i,
   input  wire        user_req_i,
   input  wire        cpu_fault_i,
   input  wire        ram_fault_i,
   input  wire        rom_fault_i,
   input  wire        keypad_fault_i,
   input  wire        conv_fault_i,
   output reg         selftest_run_o,
   output reg         mod_en_o,
   output reg  [1:0]  waveform_o,
   output reg  [31:0] freq_hz_o,
   output reg  [15:0] ampl_mv_o,
   output reg  [15:0] offset_mv_o
);

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_EXEC = 3'h1;
   localparam [2:0] ST_WAIT = 3'h2;
   localparam [2:0] ST_TEST = 3'h3;
   localparam [2:0] ST_EMIT = 3'h4;

   // self-test result by priority of the first fault found
   function [7:0] test_code;
      input cpu, ram, rom, kpd, conv;
      begin
         if (cpu)
            test_code = `TST_CPU;
         else if (ram)
            test_code = `TST_RAM;
         else if (rom)
            test_code = `TST_ROM;
         else if (kpd)
            test_code = `TST_KEYPAD;
         else if (conv)
            test_code = `TST_CONV;
         else
            test_code = `TST_PASS;
      end
   endfunction

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   reg [2:0]  state_reg;
   reg [3:0]  op_reg;
   reg [7:0]  arg_reg;
   reg        cmd_valid_reg;
   reg [7:0]  esr_reg;
   reg [7:0]  esr_next;
   reg [7:0]  ese_reg;
   reg        err_reg;
   reg [7:0]  tst_result_reg;
   reg [31:0] tst_cnt_reg;
   reg [71:0] buf_reg;
   reg [3:0]  len_reg;

   // ----------------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------------
   wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_cmd   = req & wb_we_i & (wb_adr_i == `OFS_CMD) & wb_sel_i[0];
   wire rd_reply = req & ~wb_we_i & (wb_adr_i == `OFS_REPLY);
   wire rd_esr   = req & ~wb_we_i & (wb_adr_i == `OFS_ESR);
   wire cmd_take = wr_cmd & ~cmd_valid_reg & (state_reg == ST_IDLE);
   wire cmd_drop = wr_cmd & ~cmd_take;

   // ----------------------------------------------------------------------
   // reply queue and decimal conversion
   // ----------------------------------------------------------------------
   wire [7:0]  q_data;
   wire        q_full;
   wire        q_empty;
   wire        q_push = (state_reg == ST_EMIT) & (len_reg != 4'h0) & ~q_full;
   wire [7:0]  conv_in;
   wire [31:0] conv_text;
   wire [2:0]  conv_len;

   reply_queue #(
      .WIDTH (8),
      .DEPTH (QUEUE_DEPTH),
      .AW    (QUEUE_AW)
   ) u_queue (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .push_i     (q_push),
      .data_i     (buf_reg[7:0]),
      .pop_i      (rd_reply),
      .data_o     (q_data),
      .full_o     (q_full),
      .empty_o    (q_empty)
   );

   // value to print depends on the command in hand
   assign conv_in = (state_reg == ST_TEST) ?
                    test_code(cpu_fault_i, ram_fault_i, rom_fault_i,
                              keypad_fault_i, conv_fault_i) :
                    (op_reg == `OP_ESE_Q) ? ese_reg : esr_reg;

   dec_ascii u_dec (
      .value_i (conv_in),
      .text_o  (conv_text),
      .len_o   (conv_len)
   );

   // ----------------------------------------------------------------------
   // status byte
   // ----------------------------------------------------------------------
   wire [7:0] stb_val;
   assign stb_val[`STB_SWEEP_DONE] = ~sweep_busy_i;
   assign stb_val[`STB_MOD_EN]     = mod_en_o;
   assign stb_val[3:2]             = 2'b00;
   assign stb_val[`STB_MAV]        = ~q_empty;
   assign stb_val[`STB_ESB]        = |(esr_reg & ese_reg);
   assign stb_val[6]               = 1'b0;
   assign stb_val[`STB_ERR]        = err_reg;

   wire exec_cls  = (state_reg == ST_EXEC) & (op_reg == `OP_CLS);
   wire exec_esrq = (state_reg == ST_EXEC) & (op_reg == `OP_ESR_Q);
   wire ops_done  = ~op_busy_i;
   wire opc_set   = (state_reg == ST_WAIT) & ops_done & (op_reg == `OP_OPC);
   wire qerr_ev   = rd_reply & q_empty;

   // ----------------------------------------------------------------------
   // event status next value: clears first, new events win over clears
   // ----------------------------------------------------------------------
   always @* begin
      esr_next = esr_reg;
      if (exec_cls | exec_esrq | rd_esr)
         esr_next = 8'h00;
      if (opc_set)
         esr_next[`ESR_OPC] = 1'b1;
      if (qerr_ev)
         esr_next[`ESR_QERR] = 1'b1;
      if (dev_err_i)
         esr_next[`ESR_DERR] = 1'b1;
      if (exec_err_i)
         esr_next[`ESR_EERR] = 1'b1;
      if (cmd_drop)
         esr_next[`ESR_CERR] = 1'b1;
      if ((state_reg == ST_EXEC) & (op_reg > `OP_ESR_Q))
         esr_next[`ESR_CERR] = 1'b1;
      if (user_req_i)
         esr_next[`ESR_URQ] = 1'b1;
   end

   // ----------------------------------------------------------------------
   // status registers
   // ----------------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         esr_reg <= 8'h00;
         esr_reg[`ESR_PON] <= 1'b1;
         ese_reg <= 8'h00;
         err_reg <= 1'b0;
      end else begin
         esr_reg <= esr_next;
         if ((state_reg == ST_EXEC) & (op_reg == `OP_ESE))
            ese_reg <= arg_reg;
         if (cmd_drop | qerr_ev)
            err_reg <= 1'b1;
         else if (exec_cls)
            err_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // wishbone slave: ack one cycle after the request, registered data
   // ----------------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h0000_0000;
         if (req & ~wb_we_i) begin
            case (wb_adr_i)
               `OFS_CMD:
                  wb_dat_o <= {24'h00_0000, 5'h00, state_reg == ST_WAIT,
                               state_reg != ST_IDLE, cmd_valid_reg};
               `OFS_REPLY:
                  wb_dat_o <= q_empty ? 32'h0000_0000
                                      : {23'h00_0000, 1'b1, q_data};
               `OFS_STB:
                  wb_dat_o <= {24'h00_0000, stb_val};
               `OFS_ESE:
                  wb_dat_o <= {24'h00_0000, ese_reg};
               `OFS_ESR:
                  wb_dat_o <= {24'h00_0000, esr_reg};
               `OFS_TST:
                  wb_dat_o <= {24'h00_0000, tst_result_reg};
               default:
                  wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // command latch
   // ----------------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         cmd_valid_reg <= 1'b0;
         op_reg        <= `OP_NOP;
         arg_reg       <= 8'h00;
      end else if (cmd_take) begin
         cmd_valid_reg <= 1'b1;
         op_reg        <= wb_dat_i[3:0];
         arg_reg       <= wb_dat_i[15:8];
      end else if (state_reg == ST_IDLE) begin
         cmd_valid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         state_reg      <= ST_IDLE;
         tst_cnt_reg    <= 32'h0000_0000;
         tst_result_reg <= `TST_PASS;
         selftest_run_o <= 1'b0;
         buf_reg        <= 72'h00_0000_0000_0000_0000;
         len_reg        <= 4'h0;
         mod_en_o       <= 1'b0;
         waveform_o     <= `WAVE_SINE;
         freq_hz_o      <= `DEF_FREQ_HZ;
         ampl_mv_o      <= `DEF_AMPL_MV;
         offset_mv_o    <= `DEF_OFFS_MV;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cmd_valid_reg)
                  state_reg <= ST_EXEC;
            end
            ST_EXEC: begin
               state_reg <= ST_IDLE;
               case (op_reg)
                  `OP_IDN_Q: begin
                     // maker tag high byte only, model, serial 0, revision 0, then newline
                     buf_reg <= {`CH_LF, `CH_ZERO, `CH_COMMA, `CH_ZERO,
                                 `CH_COMMA, MODEL_TAG[7:0],
                                 MODEL_TAG[15:8], `CH_COMMA,
                                 MAKER_TAG[15:8]};
                     len_reg   <= 4'h9;
                     state_reg <= ST_EMIT;
                  end
                  `OP_RST: begin
                     mod_en_o    <= 1'b0;
                     waveform_o  <= `WAVE_SINE;
                     freq_hz_o   <= `DEF_FREQ_HZ;
                     ampl_mv_o   <= `DEF_AMPL_MV;
                     offset_mv_o <= `DEF_OFFS_MV;
                  end
                  `OP_TST_Q: begin
                     tst_cnt_reg    <= 32'h0000_0000;
                     selftest_run_o <= 1'b1;
                     state_reg      <= ST_TEST;
                  end
                  `OP_WAI, `OP_OPC, `OP_OPC_Q:
                     state_reg <= ST_WAIT;
                  `OP_ESE_Q, `OP_ESR_Q: begin
                     buf_reg   <= {40'h00_0000_0000, conv_text};
                     len_reg   <= {1'b0, conv_len};
                     state_reg <= ST_EMIT;
                  end
                  default:
                     state_reg <= ST_IDLE;
               endcase
            end
            ST_WAIT: begin
               if (ops_done) begin
                  if (op_reg == `OP_OPC_Q) begin
                     buf_reg   <= {56'h00_0000_0000_0000, `CH_LF, `CH_ONE};
                     len_reg   <= 4'h2;
                     state_reg <= ST_EMIT;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_TEST: begin
               tst_cnt_reg <= tst_cnt_reg + 1'b1;
               if (tst_cnt_reg == SELFTEST_CYCLES - 1) begin
                  selftest_run_o <= 1'b0;
                  tst_result_reg <= conv_in;
                  buf_reg   <= {40'h00_0000_0000, conv_text};
                  len_reg   <= {1'b0, conv_len};
                  state_reg <= ST_EMIT;
               end
            end
            ST_EMIT: begin
               if (len_reg == 4'h0) begin
                  state_reg <= ST_IDLE;
               end else if (~q_full) begin
                  buf_reg <= {8'h00, buf_reg[71:8]};
                  len_reg <= len_reg - 4'h1;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule // cmd_status_unit

// ### hw/dec_ascii.v
// converts an 8-bit value into a newline-terminated ascii decimal string
`timescale 1ns/1ps
`include "cmd_status_regs.vh"

module dec_ascii (
   input  wire [7:0]  value_i,
   output wire [31:0] text_o,
   output wire [2:0]  len_o
);

   // split into digits
   wire [7:0] hund = value_i / 8'h64;
   wire [7:0] rest = value_i - hund * 8'h64;
   wire [7:0] tens = rest / 8'h0A;
   wire [7:0] ones = rest - tens * 8'h0A;
   wire [7:0] a2   = `CH_ZERO + hund;
   wire [7:0] a1   = `CH_ZERO + tens;
   wire [7:0] a0   = `CH_ZERO + ones;

   // lowest byte goes out first, leading zeros dropped
   assign text_o = (hund != 8'h00) ? {`CH_LF, a0, a1, a2} :
                   (tens != 8'h00) ? {8'h00, `CH_LF, a0, a1} :
                                     {16'h0000, `CH_LF, a0};
   assign len_o  = (hund != 8'h00) ? 3'h4 :
                   (tens != 8'h00) ? 3'h3 : 3'h2;

endmodule // dec_ascii

// ### hw/reply_queue.v
// reply queue of characters held in flip-flops
`timescale 1ns/1ps

module reply_queue #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             core_clk_i,
   input  wire             srst_i,
   input  wire             push_i,
   input  wire [WIDTH-1:0] data_i,
   input  wire             pop_i,
   output wire [WIDTH-1:0] data_o,
   output wire             full_o,
   output wire             empty_o
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_reg;
   reg [AW-1:0]    rd_reg;
   reg [AW:0]      cnt_reg;

   wire do_push = push_i & ~full_o;
   wire do_pop  = pop_i & ~empty_o;

   assign full_o  = (cnt_reg == DEPTH[AW:0]);
   assign empty_o = (cnt_reg == {(AW+1){1'b0}});
   assign data_o  = mem_reg[rd_reg];

   // pointer and count upkeep
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_reg  <= {AW{1'b0}};
         rd_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (do_push)
            wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_reg + 1'b1;
         if (do_pop)
            rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_reg + 1'b1;
         if (do_push & ~do_pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (do_pop & ~do_push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // storage write
   always @(posedge core_clk_i) begin
      if (do_push)
         mem_reg[wr_reg] <= data_i;
   end

endmodule // reply_queue

// ### sim/cmd_status_unit_properties.sv
// port assertions of the command unit
`timescale 1ns/1ps
module cmd_status_unit_properties #(
   parameter SELFTEST_CYCLES = 8
) (
   input wire        core_clk_i,
   input wire        srst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        selftest_run_o,
   input wire        mod_en_o,
   input wire [1:0]  waveform_o,
   input wire [31:0] freq_hz_o,
   input wire [15:0] ampl_mv_o,
   input wire [15:0] offset_mv_o
);
   reg [15:0] run_cnt_reg;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // counts cycles of one self-test
   always @(posedge core_clk_i) begin
      if (srst_i || !selftest_run_o)
         run_cnt_reg <= 16'h0000;
      else
         run_cnt_reg <= run_cnt_reg + 16'h0001;
   end
   // bus answers
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack missing after request");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_dat_idle: assert property (p_dat_idle)
      else $error("read data outside answer");
   property p_unmapped;
      wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h20)
         |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   // instrument defaults
   property p_rst_defaults;
      $fell(srst_i) |-> !mod_en_o && waveform_o == 2'h0 &&
         freq_hz_o == 32'h0000_03E8 && ampl_mv_o == 16'h03E8 &&
         offset_mv_o == 16'h0000;
   endproperty
   a_rst_defaults: assert property (p_rst_defaults)
      else $error("settings wrong after reset");
   property p_set_defaults;
      $changed(freq_hz_o) || $changed(ampl_mv_o) ||
         $changed(offset_mv_o) || $changed(waveform_o)
         |-> freq_hz_o == 32'h0000_03E8 && ampl_mv_o == 16'h03E8 &&
         offset_mv_o == 16'h0000 && waveform_o == 2'h0 && !mod_en_o;
   endproperty
   a_set_defaults: assert property (p_set_defaults)
      else $error("settings moved off defaults");
   // self-test duration
   property p_selftest_len;
      $fell(selftest_run_o) |-> run_cnt_reg >= SELFTEST_CYCLES;
   endproperty
   a_selftest_len: assert property (p_selftest_len)
      else $error("self-test too short");
   property p_selftest_end;
      $rose(selftest_run_o) |-> ##[1:12] !selftest_run_o;
   endproperty
   a_selftest_end: assert property (p_selftest_end)
      else $error("self-test does not end");
endmodule // cmd_status_unit_properties

bind cmd_status_unit cmd_status_unit_properties #(
   .SELFTEST_CYCLES(SELFTEST_CYCLES)
) props_i (
   .core_clk_i(core_clk_i),
   .srst_i(srst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .selftest_run_o(selftest_run_o),
   .mod_en_o(mod_en_o),
   .waveform_o(waveform_o),
   .freq_hz_o(freq_hz_o),
   .ampl_mv_o(ampl_mv_o),
   .offset_mv_o(offset_mv_o)
);

// ### sim/cmd_status_unit_tb.sv
// self-checking bench of the command unit over wishbone
`timescale 1ns/1ps
module cmd_status_unit_tb;
   reg         clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
   reg         ureq = 0, go = 0;
   reg  [7:0]  adr = 0;
   reg  [4:0]  flt = 0;
   reg  [1:0]  evt = 0;
   reg  [31:0] wdat = 0, rd;
   wire [31:0] dat;
   wire        ack, busy;
   integer     n_mismatch = 0, n_compared = 0, i;

   // 10 MHz clock
   initial forever #50 clk = ~clk;

   instr_model instr_model_i (.core_clk_i(clk), .srst_i(srst),
      .start_i(go), .len_i(8'd20), .op_busy_o(busy));

   cmd_status_unit #(.SELFTEST_CYCLES(8), .MAKER_TAG(16'h4142),
      .MODEL_TAG(16'h3031)) cmd_status_unit_i (
      .core_clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat), .wb_ack_o(ack), .op_busy_i(busy),
      .sweep_busy_i(1'b0), .exec_err_i(evt[0]), .dev_err_i(evt[1]),
      .user_req_i(ureq), .cpu_fault_i(flt[0]), .ram_fault_i(flt[1]),
      .rom_fault_i(flt[2]), .keypad_fault_i(flt[3]),
      .conv_fault_i(flt[4]), .selftest_run_o(), .mod_en_o(),
      .waveform_o(), .freq_hz_o(), .ampl_mv_o(), .offset_mv_o());

   task summarize;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_mismatch);
         if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   // one classic wishbone cycle, bounded wait on ack
   task bus(input w, input [7:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge clk);
         cyc <= 1;
         stb <= 1;
         we <= w;
         adr <= a;
         wdat <= d;
         k = 0;
         @(posedge clk);
         while (ack !== 1'b1 && k < 50) begin
            @(posedge clk);
            k = k + 1;
         end
         rd = dat;
         cyc <= 0;
         stb <= 0;
         if (k == 50) begin
            n_mismatch = n_mismatch + 1;
            summarize;
         end
      end
   endtask

   // issue a command, poll until the unit is idle
   task cmd(input [3:0] op, input [7:0] arg);
      integer k;
      begin
         bus(1, 8'h00, {16'h0000, arg, 4'h0, op});
         rd = 32'h0000_0007;
         for (k = 0; rd[2:0] !== 3'h0 && k < 300; k = k + 1)
            bus(0, 8'h00, 32'h0000_0000);
         if (k == 300) begin
            n_mismatch = n_mismatch + 1;
            summarize;
         end
      end
   endtask

   // reads reply chars, nonzero bytes of s from the top
   task reply(input [31:0] s);
      integer k;
      begin
         for (k = 3; k >= 0; k = k - 1)
            if (s[8*k+:8] != 8'h00) begin
               bus(0, 8'h04, 32'h0000_0000);
               chk(rd, {23'h0, 1'b1, s[8*k+:8]});
            end
      end
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      srst <= 0;
      bus(0, 8'h10, 0);
      chk(rd, 32'h0000_0080);
      bus(0, 8'h10, 0);
      chk(rd, 32'h0000_0000);
      cmd(4'h8, 8'd255);
      cmd(4'h9, 8'd0);
      reply({"255", 8'h0A});
      bus(1, 8'h0C, 0);
      bus(0, 8'h0C, 0);
      chk(rd, 32'h0000_00FF);
      bus(0, 8'h20, 0);
      chk(rd, 32'h0000_0000);
      for (i = 0; i < 6; i = i + 1) begin
         flt <= (i == 0) ? 5'h00 : 5'h01 << (i - 1);
         cmd(4'h3, 8'd0);
         reply({16'h0000, 8'h30 + i[7:0], 8'h0A});
         bus(0, 8'h14, 0);
         chk(rd, i);
      end
      flt <= 5'h00;
      cmd(4'h8, 8'd5);
      cmd(4'h9, 8'd0);
      cmd(4'h2, 8'd0);
      bus(0, 8'h0C, 0);
      chk(rd, 32'h0000_0005);
      bus(0, 8'h08, 0);
      chk(rd[4], 1'b1);
      reply({16'h0000, "5", 8'h0A});
      @(posedge clk);
      ureq <= 1;
      @(posedge clk);
      ureq <= 0;
      bus(0, 8'h08, 0);
      chk(rd[5], 1'b0);
      cmd(4'h8, 8'd64);
      bus(0, 8'h08, 0);
      chk(rd[5], 1'b1);
      cmd(4'h9, 8'd0);
      cmd(4'h7, 8'd0);
      bus(0, 8'h08, 0);
      chk(rd, 32'h0000_0011);
      bus(0, 8'h10, 0);
      chk(rd, 32'h0000_0000);
      reply({8'h00, "64", 8'h0A});
      for (i = 4; i < 7; i = i + 1) begin
         @(posedge clk);
         go <= 1;
         @(posedge clk);
         go <= 0;
         cmd(i[3:0], 8'd0);
         chk(busy, 1'b0);
      end
      bus(0, 8'h10, 0);
      chk(rd, 32'h0000_0001);
      reply({16'h0000, "1", 8'h0A});
      // execution and device errors, then the event status query
      @(posedge clk);
      evt <= 2'h3;
      @(posedge clk);
      evt <= 2'h0;
      cmd(4'hA, 8'd0);
      reply({8'h00, "24", 8'h0A});
      bus(0, 8'h10, 0);
      chk(rd, 32'h0000_0000);
      // identification reply, four comma fields
      cmd(4'h1, 8'd0);
      reply("A,01");
      reply(",0,0");
      reply(32'h0000_000A);
      summarize;
   end
endmodule // cmd_status_unit_tb

// ### sim/instr_model.sv
// busy model of the instrument operation behind the command unit
`timescale 1ns/1ps
module instr_model (
   input  wire       core_clk_i,
   input  wire       srst_i,
   input  wire       start_i,
   input  wire [7:0] len_i,
   output wire       op_busy_o
);
   reg [7:0] cnt_reg;
   // counts down an operation started by the bench
   always @(posedge core_clk_i) begin
      if (srst_i)
         cnt_reg <= 8'h00;
      else if (start_i)
         cnt_reg <= len_i;
      else if (cnt_reg != 8'h00)
         cnt_reg <= cnt_reg - 8'h01;
   end
   assign op_busy_o = (cnt_reg != 8'h00);
endmodule // instr_model
